// File: atr_defines.svh
/*
 * Constants of the alarm, trigger and reset register bank: register indices,
 * field positions, reset values and codes.
 * Assumes it is included by bare name by every file that needs it.
 */
`ifndef ATR_DEFINES_SVH
`define ATR_DEFINES_SVH

// ****************************************************************
// Register indices; the APB byte address is four times the index.
// ****************************************************************
`define ATR_IDX_ALARM_PIN_CONFIG 6'h1b
`define ATR_IDX_CONVERSION_TRIGGER 6'h1c
`define ATR_IDX_SOFTWARE_RESET 6'h1d
`define ATR_IDX_ALARM_STATUS 6'h1e

// ****************************************************************
// Field positions.
// ****************************************************************
`define ATR_CFG_LATCH_DIS_BIT 15
`define ATR_CFG_POLARITY_BIT 14
`define ATR_CFG_SOURCE_BIT 13
`define ATR_CFG_ENABLE_MSB 12
`define ATR_TRIG_SYNC_LOAD_BIT 1
`define ATR_TRIG_CONV_GO_BIT 0
`define ATR_SRST_MSB 3
`define ATR_STATUS_RSVD_BIT 11

// ****************************************************************
// Reset values and codes.
// ****************************************************************
`define ATR_CFG_RESET 16'h0000
`define ATR_STATUS_RESET 16'h0000
`define ATR_SRST_CODE 4'hc
`define ATR_PIN_IDLE_LEVEL 1'b1

`endif

// File: atr_pkg.sv
/*
 * Types shared by the alarm, trigger and reset register bank.
 * Assumes nothing of its surroundings.
 */
package atr_pkg;

    // ****************************************************************
    // Alarm output pin configuration, laid out as the register.
    // ****************************************************************
    typedef struct packed {
        logic alarm_latch_disable;
        logic alarm_pin_polarity;
        logic threshold_source_select;
        logic [12:0] alarm_enable;
    } atr_cfg_t;

    // ****************************************************************
    // Raw alarm conditions from the monitors.
    // ****************************************************************
    typedef struct packed {
        logic [3:0] high_limit;
        logic [7:0] misc;
        logic [3:0] internal_adc_channel;
        logic [3:0] current_sense;
    } atr_alarm_in_t;

endpackage

// File: atr_alarm_status.sv
/*
 * Alarm status flags with optional latching and the alarm output pin.
 * Assumes conditions are synchronous to sys_clk and that reads of the
 * status register arrive as a clear pulse with the value that was read.
 */
`include "atr_defines.svh"

module atr_alarm_status (
    // Clock, reset and enable.
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic soft_clear,
    // Configuration.
    input wire atr_pkg::atr_cfg_t cfg,
    // Conditions and status read.
    input wire logic [15:0] cond,
    input wire logic rd_clear,
    input wire logic [15:0] rd_value,
    // Results.
    output logic [15:0] status,
    output logic alarm_output_pin
);

    logic [15:0] next_status;
    logic next_pin;
    logic [15:0] en_map;
    logic [15:0] live;
    logic active;

    // Maps each enable bit onto the status bits it covers.
    always_comb begin
        en_map = {{2{cfg.alarm_enable[12]}}, {2{cfg.alarm_enable[11]}}, 1'b0,
                  cfg.alarm_enable[10:0]};
        live = cond;
        live[`ATR_STATUS_RSVD_BIT] = 1'b0;
    end

    // Next status: live flags, or sticky flags cleared only by a read of them or by soft_clear.
    always_comb begin
        if (soft_clear) begin
            next_status = `ATR_STATUS_RESET;
        end else if (cfg.alarm_latch_disable) begin
            next_status = live;
        end else if (rd_clear) begin
            next_status = live | (status & ~rd_value);
        end else begin
            next_status = live | status;
        end
        active = |(status & en_map);
        next_pin = cfg.alarm_pin_polarity ? active : ~active;
    end

    // Registers the flags and the pin.
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            status <= `ATR_STATUS_RESET;
            alarm_output_pin <= `ATR_PIN_IDLE_LEVEL;
        end else if (clk_en) begin
            status <= next_status;
            alarm_output_pin <= next_pin;
        end
    end

endmodule

// File: atr_regs.sv
/*
 * Alarm output configuration, conversion trigger and software reset
 * registers with an APB slave and the alarm status register.
 * Assumes a single clock, conditions and converter handshakes synchronous
 * to sys_clk, and an APB master that keeps the protocol.
 */
// Summary of operation
// - Latching on: flag sets on event, stays until condition gone and read.
// - Latching on: a flag is cleared before it has been read only by reset or a soft reset.
// - Latching off: a flag follows its condition, read or not.
// - Alarm pin is active low with polarity 0, active high with 1.
// - Source select 0 uses internal ADC alarms, 1 uses current sense.
// - Each enable bit lets its alarm drive the pin; cleared bit masks it.
// - Configuration resets to zero: latched, active low, ADC, all masked.
// - Writing 1 to trigger bit 1 loads all synchronous converter outputs.
// - The synchronous load bit clears itself once outputs are updated.
// - Writing 1 to trigger bit 0 starts a conversion; bit self-clears.
// - A start while the converter is not ready is ignored.
// - Code 1100 in the reset field returns the device to defaults.
// - The reset field clears itself after the reset.
// - Trigger register is write-only, resets to zero, bits 15-2 reserved.
// - Alarm status sits at index 0x1E, read-only, resets to zero.
// - Alarm pin configuration sits at index 0x1B, resets to 0x0000.
`include "atr_defines.svh"

module atr_regs (
    // Clock, reset and enable.
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic clk_en,
    // APB slave.
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Alarm conditions from the monitors.
    input wire atr_pkg::atr_alarm_in_t alarm_in,
    // Converter control.
    input wire logic conv_ready,
    input wire logic dac_updated,
    output logic sync_output_load,
    output logic conversion_go,
    output logic threshold_source_select,
    // Device-wide reset and alarm pin.
    output logic soft_reset_pulse,
    output logic alarm_output_pin
);

    // ****************************************************************
    // Address decode.
    // ****************************************************************

    // True when the byte address selects the aligned word of a register.
    function automatic logic atr_hit(input logic [7:0] addr, input logic [5:0] idx);
        atr_hit = (addr[1:0] == 2'h0) && (addr[7:2] == idx);
    endfunction

    logic hit_cfg;
    logic hit_trig;
    logic hit_srst;
    logic hit_status;
    logic mapped;
    logic setup;
    logic access;
    logic wr_done;
    logic rd_done;

    // Phase and target of the current APB transfer.
    always_comb begin
        hit_cfg = atr_hit(paddr, `ATR_IDX_ALARM_PIN_CONFIG);
        hit_trig = atr_hit(paddr, `ATR_IDX_CONVERSION_TRIGGER);
        hit_srst = atr_hit(paddr, `ATR_IDX_SOFTWARE_RESET);
        hit_status = atr_hit(paddr, `ATR_IDX_ALARM_STATUS);
        mapped = hit_cfg | hit_trig | hit_srst | hit_status;
        setup = psel & ~penable;
        access = psel & penable;
        wr_done = access & pwrite & clk_en;
        rd_done = access & ~pwrite & clk_en;
    end

    // Zero wait states; a frozen block holds the access phase open.
    always_comb begin
        pready = clk_en;
        pslverr = access & (~mapped | (pwrite & hit_status));
    end

    // ****************************************************************
    // Registers.
    // ****************************************************************

    atr_pkg::atr_cfg_t cfg;
    atr_pkg::atr_cfg_t next_cfg;
    logic [31:0] next_prdata;
    logic srst_now;
    logic next_soft_reset_pulse;
    logic next_sync_output_load;
    logic next_conversion_go;
    logic [15:0] status;
    logic [15:0] cond;

    // Soft reset is taken only on the exact code; other codes do nothing.
    always_comb begin
        srst_now = wr_done & hit_srst &
                   (pwdata[`ATR_SRST_MSB:0] == `ATR_SRST_CODE);
        next_soft_reset_pulse = srst_now;
    end

    // Configuration writes; soft reset brings it back to zero.
    always_comb begin
        next_cfg = cfg;
        if (srst_now) begin
            next_cfg = `ATR_CFG_RESET;
        end else if (wr_done & hit_cfg) begin
            next_cfg = atr_pkg::atr_cfg_t'(pwdata[15:0]);
        end
    end

    // Read data is captured in the setup phase; write-only registers read zero.
    always_comb begin
        next_prdata = prdata;
        if (setup & ~pwrite & clk_en) begin
            next_prdata = 32'h0000_0000;
            if (hit_cfg) begin
                next_prdata = {16'h0000, cfg};
            end else if (hit_status) begin
                next_prdata = {16'h0000, status};
            end
        end
    end

    // Trigger bits: the load request stays until outputs update, a new write wins.
    always_comb begin
        next_sync_output_load = sync_output_load;
        if (srst_now) begin
            next_sync_output_load = 1'b0;
        end else if (wr_done & hit_trig & pwdata[`ATR_TRIG_SYNC_LOAD_BIT]) begin
            next_sync_output_load = 1'b1;
        end else if (dac_updated) begin
            next_sync_output_load = 1'b0;
        end
        next_conversion_go = wr_done & hit_trig & pwdata[`ATR_TRIG_CONV_GO_BIT] &
                             conv_ready & ~srst_now;
    end

    // Registers all control state.
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            cfg <= `ATR_CFG_RESET;
            prdata <= 32'h0000_0000;
            soft_reset_pulse <= 1'b0;
            sync_output_load <= 1'b0;
            conversion_go <= 1'b0;
        end else if (clk_en) begin
            cfg <= next_cfg;
            prdata <= next_prdata;
            soft_reset_pulse <= next_soft_reset_pulse;
            sync_output_load <= next_sync_output_load;
            conversion_go <= next_conversion_go;
        end
    end

    // ****************************************************************
    // Alarm sources and status.
    // ****************************************************************

    // Threshold alarms come from the ADC channels or the current sense.
    always_comb begin
        cond = {alarm_in.high_limit, alarm_in.misc,
                cfg.threshold_source_select ? alarm_in.current_sense
                                            : alarm_in.internal_adc_channel};
        threshold_source_select = cfg.threshold_source_select;
    end

    atr_alarm_status u_status (
        .sys_clk(sys_clk),
        .reset(reset),
        .clk_en(clk_en),
        .soft_clear(srst_now),
        .cfg(cfg),
        .cond(cond),
        .rd_clear(rd_done & hit_status),
        .rd_value(prdata[15:0]),
        .status(status),
        .alarm_output_pin(alarm_output_pin)
    );

    // ****************************************************************
    // Assertions.
    // ****************************************************************

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (reset);

    logic [15:0] en_map;

    // Enable bits spread over the status bits, for the pin check.
    always_comb begin
        en_map = {{2{cfg.alarm_enable[12]}}, {2{cfg.alarm_enable[11]}}, 1'b0,
                  cfg.alarm_enable[10:0]};
    end

    property p_cfg_reset;
        $fell(reset) |-> (cfg == `ATR_CFG_RESET) && (status == `ATR_STATUS_RESET);
    endproperty
    a_cfg_reset: assert property (p_cfg_reset) else $error("config not zero");

    property p_latch_hold;
        (clk_en && !cfg.alarm_latch_disable && !(rd_done && hit_status) && !srst_now)
            |=> ((status & $past(status)) == $past(status));
    endproperty
    a_latch_hold: assert property (p_latch_hold) else $error("latched flag lost unread");

    property p_unlatched;
        (clk_en && cfg.alarm_latch_disable && !srst_now)
            |=> (status == ($past(cond) & 16'hf7ff));
    endproperty
    a_unlatched: assert property (p_unlatched) else $error("flag not live");

    property p_read_clears;
        (clk_en && !cfg.alarm_latch_disable && rd_done && hit_status && !srst_now)
            |=> (status == (($past(cond) & 16'hf7ff) |
                            ($past(status) & ~$past(prdata[15:0]))));
    endproperty
    a_read_clears: assert property (p_read_clears) else $error("read clear wrong");

    property p_pin_level;
        clk_en |=> (alarm_output_pin == ($past(cfg.alarm_pin_polarity) ~^
                                         (|($past(status) & $past(en_map)))));
    endproperty
    a_pin_level: assert property (p_pin_level) else $error("alarm pin level wrong");

    property p_srst_apply;
        srst_now |=> ((soft_reset_pulse && (cfg == `ATR_CFG_RESET) && !sync_output_load)
            and (clk_en |=> !soft_reset_pulse));
    endproperty
    a_srst_apply: assert property (p_srst_apply) else $error("soft reset not applied");

    property p_srst_other;
        (wr_done && hit_srst && pwdata[3:0] != 4'hc) |=> !soft_reset_pulse && $stable(cfg);
    endproperty
    a_srst_other: assert property (p_srst_other) else $error("wrong code acted");

    property p_wo_read;
        (setup && !pwrite && clk_en && (hit_trig || hit_srst)) |=> (prdata == 32'h0);
    endproperty
    a_wo_read: assert property (p_wo_read) else $error("write-only register read nonzero");

    property p_go_ignored;
        (wr_done && hit_trig && pwdata[0] && !conv_ready) |=> !conversion_go;
    endproperty
    a_go_ignored: assert property (p_go_ignored) else $error("start taken when busy");

    property p_go_pulse;
        (wr_done && hit_trig && pwdata[0] && conv_ready && !srst_now)
            |=> (conversion_go and (clk_en |=> !conversion_go));
    endproperty
    a_go_pulse: assert property (p_go_pulse) else $error("start pulse wrong");

    property p_sync_hold;
        (clk_en && sync_output_load && !dac_updated && !srst_now) |=> sync_output_load;
    endproperty
    a_sync_hold: assert property (p_sync_hold) else $error("load request dropped early");

    property p_sync_clear;
        (clk_en && sync_output_load && dac_updated && !(wr_done && hit_trig && pwdata[1]))
            |=> !sync_output_load;
    endproperty
    a_sync_clear: assert property (p_sync_clear) else $error("load not cleared");

    property p_source;
        (clk_en && cfg.alarm_latch_disable && !srst_now) |=>
            (status[3:0] == ($past(cfg.threshold_source_select) ?
                             $past(alarm_in.current_sense) :
                             $past(alarm_in.internal_adc_channel)));
    endproperty
    a_source: assert property (p_source) else $error("threshold source wrong");

    c_soft_reset: cover property (srst_now);
    c_go: cover property (wr_done && hit_trig && pwdata[0] && conv_ready);
    c_sync_done: cover property (sync_output_load && dac_updated);
    c_read_clear: cover property (rd_done && hit_status && |prdata[15:0]);

endmodule

// File: atr_host_model.sv
/*
 * Host model: an APB master that issues single register transfers.
 * Assumes a slave on the same sys_clk that may insert wait states.
 */
module atr_host_model (
    // Clock.
    input wire logic sys_clk,
    // APB master side.
    output logic [7:0] paddr,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    timeunit 1ns;
    timeprecision 1ps;

    // The bus starts idle.
    initial begin
        paddr = 8'h00;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        pwdata = 32'h0000_0000;
    end

    // One transfer; released lines are scrambled so stale values never look valid.
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [15:0] d,
                        output logic [31:0] rd, output logic err);
        @(posedge sys_clk);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= wr;
        pwdata <= {16'h0000, d}; // Upper half zero while the transfer is driven
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~a;
        pwdata <= ~pwdata;
    endtask
endmodule

// File: tb_alarm_trigger_reset_regs.sv
/*
 * Self-checking bench of the alarm, trigger and reset register bank.
 * Assumes atr_regs, atr_host_model and the shared package and header.
 */
`include "atr_defines.svh"

module tb_alarm_trigger_reset_regs;
    timeunit 1ns;
    timeprecision 1ps;

    // ****************************************************************
    // Signals and addresses.
    // ****************************************************************
    localparam logic [7:0] A_CFG = {`ATR_IDX_ALARM_PIN_CONFIG, 2'b00};
    localparam logic [7:0] A_TRG = {`ATR_IDX_CONVERSION_TRIGGER, 2'b00};
    localparam logic [7:0] A_SRS = {`ATR_IDX_SOFTWARE_RESET, 2'b00};
    localparam logic [7:0] A_STS = {`ATR_IDX_ALARM_STATUS, 2'b00};
    logic sys_clk, reset, clk_en, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    atr_pkg::atr_alarm_in_t alarm_in;
    logic conv_ready, dac_updated, sync_output_load, conversion_go;
    logic threshold_source_select, soft_reset_pulse, alarm_output_pin, err;
    logic [15:0] cfg, exp_s;
    int errors, comparisons, go, sr;

    atr_regs dut (.sys_clk(sys_clk), .reset(reset), .clk_en(clk_en), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .alarm_in(alarm_in), .conv_ready(conv_ready),
        .dac_updated(dac_updated), .sync_output_load(sync_output_load),
        .conversion_go(conversion_go), .threshold_source_select(threshold_source_select),
        .soft_reset_pulse(soft_reset_pulse), .alarm_output_pin(alarm_output_pin));
    atr_host_model host (.sys_clk(sys_clk), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));

    // ****************************************************************
    // Expectations and helpers.
    // ****************************************************************
    // Live status as the monitors present it; bit 11 is reserved.
    function automatic logic [15:0] exp_status(input atr_pkg::atr_alarm_in_t c,
                                               input logic sel);
        return {c.high_limit, 1'b0, c.misc[6:0],
                sel ? c.current_sense : c.internal_adc_channel};
    endfunction

    // Pin level from enables, polarity and status.
    function automatic logic exp_pin(input logic [15:0] cf, input logic [15:0] s);
        logic [15:0] m;
        m = {{2{cf[12]}}, {2{cf[11]}}, 1'b0, cf[10:0]};
        return cf[14] ? |(m & s) : ~|(m & s);
    endfunction

    // Counts every comparison and reports a mismatch at once.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        host.xfer(1'b1, a, d, rd, err);
        chk({31'h0, err}, 32'h0, "write refused");
    endtask

    task automatic rdc(input logic [7:0] a, input logic [15:0] e, input string what);
        host.xfer(1'b0, a, 16'h0000, rd, err);
        chk(rd, {16'h0000, e}, what);
    endtask

    task automatic tick(input int k);
        repeat (k) @(posedge sys_clk);
        #1;
    endtask

    // Counts pulse cycles in the four cycles after an access edge.
    task automatic count_pulses();
        go = 0;
        sr = 0;
        repeat (4) begin
            #1;
            go += int'(conversion_go === 1'b1);
            sr += int'(soft_reset_pulse === 1'b1);
            @(posedge sys_clk);
        end
    endtask

    task automatic report_and_stop();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // ****************************************************************
    // Clock, watchdog and test sequence.
    // ****************************************************************
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // Cuts a hang short well beyond the few hundred cycles the tests need.
    initial begin
        repeat (20000) @(posedge sys_clk);
        errors++;
        $display("watchdog expired");
        report_and_stop();
    end

    initial begin
        errors = 0;
        comparisons = 0;
        reset = 1'b1;
        clk_en = 1'b1;
        alarm_in = '0;
        conv_ready = 1'b0;
        dac_updated = 1'b0;
        void'($urandom(51725));
        repeat (10) @(posedge sys_clk);
        reset <= 1'b0;
        #1;
        chk({31'h0, alarm_output_pin}, 32'h1, "idle pin");
        rdc(A_CFG, 16'h0000, "config reset");
        rdc(A_STS, 16'h0000, "status reset");
        rdc(A_TRG, 16'h0000, "trigger read");
        rdc(A_SRS, 16'h0000, "reset field read");
        $display("test reset values done");

        // Latched flag: held while its condition stays, cleared only by a read.
        wr(A_CFG, 16'h0010);
        @(posedge sys_clk);
        alarm_in.misc <= 8'h01;
        tick(3);
        chk({31'h0, alarm_output_pin}, 32'h0, "pin active low");
        rdc(A_STS, 16'h0010, "status set");
        rdc(A_STS, 16'h0010, "status kept while condition holds");
        @(posedge sys_clk);
        alarm_in.misc <= 8'h00;
        tick(3);
        chk({31'h0, alarm_output_pin}, 32'h0, "latched pin held");
        rdc(A_STS, 16'h0010, "latched before read");
        rdc(A_STS, 16'h0000, "cleared after read");
        tick(3);
        chk({31'h0, alarm_output_pin}, 32'h1, "pin released");
        $display("test latched alarm done");

        // Unlatched random configurations and conditions.
        repeat (30) begin
            cfg = 16'h8000 | 16'($urandom_range(0, 32'h7fff));
            wr(A_CFG, cfg);
            @(posedge sys_clk);
            alarm_in <= atr_pkg::atr_alarm_in_t'(20'($urandom_range(0, 32'hfffff)));
            tick(3);
            exp_s = exp_status(alarm_in, cfg[13]);
            chk({31'h0, alarm_output_pin}, {31'h0, exp_pin(cfg, exp_s)}, "pin");
            chk({31'h0, threshold_source_select}, {31'h0, cfg[13]}, "source out");
            rdc(A_STS, exp_s, "live status");
        end
        @(posedge sys_clk);
        alarm_in <= '0;
        tick(3);
        rdc(A_STS, 16'h0000, "status follows condition");
        rdc(A_CFG, cfg, "config readback");
        $display("test unlatched alarm done");

        // Conversion start, refused start and synchronous load.
        @(posedge sys_clk);
        conv_ready <= 1'b1;
        wr(A_TRG, 16'h0001);
        count_pulses();
        chk(32'(go), 32'h1, "one conversion start");
        @(posedge sys_clk);
        conv_ready <= 1'b0;
        wr(A_TRG, 16'h0001);
        count_pulses();
        chk(32'(go), 32'h0, "start while busy");
        wr(A_TRG, 16'h0002);
        tick(4);
        chk({31'h0, sync_output_load}, 32'h1, "sync load held");
        @(posedge sys_clk);
        dac_updated <= 1'b1;
        @(posedge sys_clk);
        dac_updated <= 1'b0;
        tick(2);
        chk({31'h0, sync_output_load}, 32'h0, "sync load cleared");
        $display("test triggers done");

        // Software reset: wrong code ignored, right code restores defaults.
        wr(A_CFG, 16'h4001);
        wr(A_SRS, 16'h0005);
        count_pulses();
        chk(32'(sr), 32'h0, "other code");
        rdc(A_CFG, 16'h4001, "config kept");
        wr(A_SRS, 16'h000c);
        count_pulses();
        chk(32'(sr), 32'h1, "one reset pulse");
        rdc(A_CFG, 16'h0000, "config defaulted");
        rdc(A_SRS, 16'h0000, "reset field cleared");
        $display("test software reset done");

        // Refused accesses.
        host.xfer(1'b0, 8'h7c, 16'h0000, rd, err);
        chk({31'h0, err}, 32'h1, "unmapped read refused");
        chk(rd, 32'h0, "unmapped read data");
        host.xfer(1'b1, A_STS, 16'hffff, rd, err);
        chk({31'h0, err}, 32'h1, "status write refused");
        rdc(A_STS, 16'h0000, "status untouched");
        host.xfer(1'b1, 8'h6d, 16'hffff, rd, err);
        chk({31'h0, err}, 32'h1, "unaligned write refused");
        rdc(A_CFG, 16'h0000, "config untouched");
        $display("test refusals done");

        // Clock enable low: the bus waits and a passing condition is never seen.
        @(posedge sys_clk);
        clk_en <= 1'b0;
        alarm_in.misc <= 8'h01;
        tick(3);
        chk({31'h0, pready}, 32'h0, "pready while frozen");
        @(posedge sys_clk);
        clk_en <= 1'b1;
        alarm_in.misc <= 8'h00;
        rdc(A_STS, 16'h0000, "frozen status");
        $display("test clock enable done");
        report_and_stop();
    end
endmodule
